// File: verilog/prio_pkg.sv
package prio_pkg;
  // register byte addresses
  localparam logic [7:0] ADDR_STATUS = 8'h00;
  localparam logic [7:0] ADDR_CORE = 8'h04;
  localparam logic [7:0] ADDR_PRIO0 = 8'h08;
  localparam logic [7:0] ADDR_PRIO19 = 8'h0C;
  localparam logic [7:0] ADDR_ICTRL = 8'h10;
  localparam logic [7:0] ADDR_PEND = 8'h14;
  localparam logic [7:0] ADDR_LEVEL = 8'h18;
  // field positions
  localparam int LVL_LSB = 5;
  localparam int UPPER_BIT = 3;
  localparam int NEST_BIT = 15;
  localparam int T1_LSB = 12;
  localparam int OC1_LSB = 8;
  localparam int IC1_LSB = 4;
  localparam int INT0_LSB = 0;
  localparam int CTU_LSB = 4;
  // masks of implemented bits
  localparam logic [15:0] STATUS_MASK = 16'h00E0;
  localparam logic [15:0] CORE_MASK = 16'h0008;
  localparam logic [15:0] PRIO0_MASK = 16'h7777;
  localparam logic [15:0] PRIO19_MASK = 16'h0070;
  localparam logic [15:0] ICTRL_MASK = 16'h8000;
  // reset values
  localparam logic [15:0] STATUS_RST = 16'h0000;
  localparam logic [15:0] CORE_RST = 16'h0000;
  localparam logic [15:0] PRIO0_RST = 16'h4444;
  localparam logic [15:0] PRIO19_RST = 16'h0040;
  localparam logic [15:0] ICTRL_RST = 16'h0000;
  localparam int NSRC = 5;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : prio_pkg

// File: verilog/level_compare.sv
`timescale 1ns/1ns
`default_nettype none
module level_compare (
  // inputs
  input wire logic [2:0] src_prio,
  input wire logic src_pend,
  input wire logic [3:0] cpu_level,
  // result
  output logic accept
);
  // 000 disables; upper bit set means level 8..15 so no 3-bit priority beats it
  assign accept = src_pend && (src_prio != 3'h0)
    && ({1'b0, src_prio} > cpu_level); // [RQ8] [RQ14] [RQ4] [RQ7] [RQ9]
endmodule : level_compare
`default_nettype wire

// File: verilog/prio_regs.sv
`timescale 1ns/1ns
`default_nettype none
module prio_regs (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // write port
  input wire logic wr_en,
  input wire logic [15:0] wr_data,
  // contents
  output logic [15:0] value
);
  parameter logic [15:0] MASK = 16'h0000;
  parameter logic [15:0] RST = 16'h0000;
  logic [15:0] value_ff;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      value_ff <= RST;
    else if (wr_en)
      value_ff <= wr_data & MASK; // [RQ13]
  end
  assign value = value_ff;
endmodule : prio_regs
`default_nettype wire

// File: verilog/interrupt_priority_level_logic.sv
// Overview of operation
// RQ1: level is upper bit (msb) joined with 3-bit status field
// RQ2: field 111 gives level 7 or 15; user interrupts blocked
// RQ3: codes 000..110 give 0..6; upper bit adds 8
// RQ4: upper bit set blocks every user interrupt
// RQ5: nesting disable set makes the 3-bit field read-only
// RQ6: upper bit reads 1 exactly when level exceeds 7
// RQ7: source fields are 3 bits; 111 is priority 7, highest
// RQ8: source field 000 disables that source
// RQ9: 001 is priority 1; codes between map linearly
// RQ10: word 0 holds timer one at 14:12, compare one at 10:8
// RQ11: word 0 holds capture one at 6:4, external zero at 2:0
// RQ12: word 19 holds only charge-time unit priority at 6:4
// RQ13: unimplemented bits read zero and ignore writes
// RQ14: request presented only when priority beats current level
// RQ15: source fields reset to 100
`timescale 1ns/1ns
`default_nettype none
module interrupt_priority_level_logic (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // axi4-lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read address
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // axi4-lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // peripheral requests: t1, oc1, ic1, int0, ctu
  input wire logic [4:0] src_req,
  // to the processor core
  output logic [4:0] irq_accept,
  output logic [3:0] cpu_level,
  output logic user_irq_blocked
);
  logic [7:0] awaddr_ff;
  logic aw_have_ff;
  logic [15:0] wdata_ff;
  logic [1:0] wstrb_ff;
  logic w_have_ff;
  logic bvalid_ff;
  logic [1:0] bresp_ff;
  logic rvalid_ff;
  logic [31:0] rdata_ff;
  logic [1:0] rresp_ff;
  logic awready_ff;
  logic wready_ff;
  logic arready_ff;
  logic [15:0] status_ff;
  logic [15:0] core_ff;
  logic [15:0] ictrl_ff;
  logic [15:0] prio0_q;
  logic [15:0] prio19_q;
  logic [4:0] accept_ff;
  logic [3:0] level_ff;
  logic blocked_ff;
  logic do_write;
  logic [15:0] wr_val;
  logic [15:0] nxt_status;
  logic [3:0] cur_level;
  logic [4:0] accept_c;
  logic [2:0] src_prio [prio_pkg::NSRC];
  logic prio0_we;
  logic prio19_we;

  // write fires once both halves are held and no response is pending
  assign do_write = aw_have_ff && w_have_ff && !bvalid_ff;
  assign wr_val = {wstrb_ff[1] ? wdata_ff[15:8] : 8'h00, wstrb_ff[0] ? wdata_ff[7:0] : 8'h00};
  assign prio0_we = do_write && (awaddr_ff == prio_pkg::ADDR_PRIO0) && (wstrb_ff == 2'h3);
  assign prio19_we = do_write && (awaddr_ff == prio_pkg::ADDR_PRIO19) && (wstrb_ff == 2'h3);

  // address and data accepted independently, in either order
  // each ready is its own flop, the complement of the held flag, so no gate drives the bus
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_have_ff <= 1'b0;
      awready_ff <= 1'b1;
      awaddr_ff <= 8'h00;
    end
    else if (s_axi_awvalid && !aw_have_ff)
    begin
      aw_have_ff <= 1'b1;
      awready_ff <= 1'b0;
      awaddr_ff <= {s_axi_awaddr[7:2], 2'h0};
    end
    else if (do_write)
    begin
      aw_have_ff <= 1'b0;
      awready_ff <= 1'b1;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      w_have_ff <= 1'b0;
      wready_ff <= 1'b1;
      wdata_ff <= 16'h0000;
      wstrb_ff <= 2'h0;
    end
    else if (s_axi_wvalid && !w_have_ff)
    begin
      w_have_ff <= 1'b1;
      wready_ff <= 1'b0;
      wdata_ff <= s_axi_wdata[15:0];
      wstrb_ff <= s_axi_wstrb[1:0];
    end
    else if (do_write)
    begin
      w_have_ff <= 1'b0;
      wready_ff <= 1'b1;
    end
  end

  assign s_axi_awready = awready_ff;
  assign s_axi_wready = wready_ff;

  // write response; unmapped addresses answer slverr
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      bvalid_ff <= 1'b0;
      bresp_ff <= prio_pkg::RESP_OKAY;
    end
    else if (do_write)
    begin
      bvalid_ff <= 1'b1;
      // the two read-only words answer okay and drop the data
      case (awaddr_ff)
        prio_pkg::ADDR_STATUS, prio_pkg::ADDR_CORE, prio_pkg::ADDR_PRIO0,
        prio_pkg::ADDR_PRIO19, prio_pkg::ADDR_ICTRL, prio_pkg::ADDR_PEND,
        prio_pkg::ADDR_LEVEL: bresp_ff <= prio_pkg::RESP_OKAY;
        default: bresp_ff <= prio_pkg::RESP_SLVERR;
      endcase
    end
    else if (s_axi_bready)
      bvalid_ff <= 1'b0;
  end
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;

  // status field; frozen while nesting disable is set
  always_comb
  begin
    nxt_status = status_ff;
    if (do_write && (awaddr_ff == prio_pkg::ADDR_STATUS) && !ictrl_ff[prio_pkg::NEST_BIT]) // [RQ5]
      nxt_status = (status_ff & ~{8'h00, {8{wstrb_ff[0]}}})
        | (wr_val & prio_pkg::STATUS_MASK); // [RQ13]
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      status_ff <= prio_pkg::STATUS_RST;
    else
      status_ff <= nxt_status;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      core_ff <= prio_pkg::CORE_RST;
    else if (do_write && (awaddr_ff == prio_pkg::ADDR_CORE) && wstrb_ff[0])
      core_ff <= wr_val & prio_pkg::CORE_MASK; // [RQ13]
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      ictrl_ff <= prio_pkg::ICTRL_RST;
    else if (do_write && (awaddr_ff == prio_pkg::ADDR_ICTRL) && wstrb_ff[1])
      ictrl_ff <= wr_val & prio_pkg::ICTRL_MASK;
  end

  // word writes only for the priority words
  prio_regs #(
    .MASK(prio_pkg::PRIO0_MASK),
    .RST(prio_pkg::PRIO0_RST)
  ) u_prio0 (
    .aclk(aclk),
    .aresetn(aresetn),
    .wr_en(prio0_we),
    .wr_data(wr_val),
    .value(prio0_q)
  ); // [RQ10] [RQ11] [RQ15]

  prio_regs #(
    .MASK(prio_pkg::PRIO19_MASK),
    .RST(prio_pkg::PRIO19_RST)
  ) u_prio19 (
    .aclk(aclk),
    .aresetn(aresetn),
    .wr_en(prio19_we),
    .wr_data(wr_val),
    .value(prio19_q)
  ); // [RQ12] [RQ15]

  // effective level: upper bit on top of the status field
  assign cur_level = {core_ff[prio_pkg::UPPER_BIT],
    status_ff[prio_pkg::LVL_LSB +: 3]}; // [RQ1] [RQ3] [RQ6]

  // index follows the src_req bit order
  assign src_prio[0] = prio0_q[prio_pkg::T1_LSB +: 3]; // [RQ10]
  assign src_prio[1] = prio0_q[prio_pkg::OC1_LSB +: 3]; // [RQ10]
  assign src_prio[2] = prio0_q[prio_pkg::IC1_LSB +: 3]; // [RQ11]
  assign src_prio[3] = prio0_q[prio_pkg::INT0_LSB +: 3]; // [RQ11]
  assign src_prio[4] = prio19_q[prio_pkg::CTU_LSB +: 3]; // [RQ12]

  // a tie with the level loses: strictly greater is needed
  genvar gi;
  generate
    for (gi = 0; gi < prio_pkg::NSRC; gi++)
    begin : g_src
      level_compare u_cmp (
        .src_prio(src_prio[gi]),
        .src_pend(src_req[gi]),
        .cpu_level(cur_level),
        .accept(accept_c[gi])
      );
    end
  endgenerate

  // registered outputs to the core
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      accept_ff <= 5'h00;
      level_ff <= 4'h0;
      blocked_ff <= 1'b0;
    end
    else
    begin
      accept_ff <= accept_c; // [RQ14]
      level_ff <= cur_level;
      blocked_ff <= (cur_level[2:0] == 3'h7) || cur_level[3]; // [RQ2] [RQ4]
    end
  end
  assign irq_accept = accept_ff;
  assign cpu_level = level_ff;
  assign user_irq_blocked = blocked_ff;

  // read channel: one read under way, answer one cycle after address
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid_ff <= 1'b0;
      arready_ff <= 1'b1;
      rdata_ff <= 32'h0000_0000;
      rresp_ff <= prio_pkg::RESP_OKAY;
    end
    else if (s_axi_arvalid && !rvalid_ff)
    begin
      // data latched at the take, so it stands while rready is low
      rvalid_ff <= 1'b1;
      arready_ff <= 1'b0;
      rresp_ff <= prio_pkg::RESP_OKAY;
      case ({s_axi_araddr[7:2], 2'h0})
        prio_pkg::ADDR_STATUS: rdata_ff <= {16'h0000, status_ff};
        prio_pkg::ADDR_CORE: rdata_ff <= {16'h0000, core_ff}; // [RQ6]
        prio_pkg::ADDR_PRIO0: rdata_ff <= {16'h0000, prio0_q};
        prio_pkg::ADDR_PRIO19: rdata_ff <= {16'h0000, prio19_q};
        prio_pkg::ADDR_ICTRL: rdata_ff <= {16'h0000, ictrl_ff};
        prio_pkg::ADDR_PEND: rdata_ff <= {27'h0000000, accept_ff};
        prio_pkg::ADDR_LEVEL: rdata_ff <= {27'h0000000, blocked_ff, level_ff};
        default:
        begin
          rdata_ff <= 32'h0000_0000;
          rresp_ff <= prio_pkg::RESP_SLVERR;
        end
      endcase
    end
    else if (s_axi_rready)
    begin
      rvalid_ff <= 1'b0;
      arready_ff <= 1'b1;
    end
  end
  assign s_axi_arready = arready_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;
endmodule : interrupt_priority_level_logic
`default_nettype wire

// File: test/irq_sources.sv
`timescale 1ns/1ns
`default_nettype none
module irq_sources (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // requests wanted
  input wire logic [4:0] want,
  // toward the block
  output logic [4:0] src_req
);
  // level requests, held until the bench lets them go
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      src_req <= 5'h00;
    else
      src_req <= want;
  end
endmodule : irq_sources
`default_nettype wire

// File: test/prio_monitor.sv
`timescale 1ns/1ns
`default_nettype none
module prio_monitor (
  // clock, reset
  input wire logic aclk,
  input wire logic aresetn,
  // bus
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // core side
  input wire logic [4:0] src_req,
  input wire logic [4:0] irq_accept,
  input wire logic [3:0] cpu_level,
  input wire logic user_irq_blocked
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  bvalid_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("bvalid dropped");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata changed");
  read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read late");
  write_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
    s_axi_wready |-> ##[1:2] s_axi_bvalid) else $error("write late");
  upper_zero_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
    else $error("upper bits set");
  block_code_a: assert property (user_irq_blocked == (cpu_level[3] || cpu_level[2:0] == 3'h7))
    else $error("blocked flag wrong");
  blocked_mute_a: assert property (user_irq_blocked && $past(user_irq_blocked) |->
    irq_accept == 5'h00) else $error("accept while blocked");
  quiet_src_a: assert property (src_req == 5'h00 && $past(src_req) == 5'h00 &&
    $past(src_req, 2) == 5'h00 |-> irq_accept == 5'h00) else $error("accept unasked");
  cover property (user_irq_blocked);
  cover property (irq_accept == 5'h1F);
  cover property (s_axi_bvalid && s_axi_bresp == prio_pkg::RESP_SLVERR);
endmodule : prio_monitor
bind interrupt_priority_level_logic prio_monitor u_mon (.*);
`default_nettype wire

// File: test/interrupt_priority_level_logic_tb.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin err_count++; \
  $display("CHECK FAILED %0t got %0h exp %0h", $time, g, e); end end
module interrupt_priority_level_logic_tb;
  typedef struct {logic [7:0] a; logic [31:0] d; logic [31:0] e;} row_t;
  logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic s_axi_arready, s_axi_rvalid, user_irq_blocked;
  logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb = 4'hF, cpu_level, lv;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic [4:0] src_req, irq_accept, want = 0;
  int err_count = 0, tests_run = 0;
  // nesting disable set in row 4 must freeze the status field in row 5
  row_t rows [10] = '{'{8'h00, 32'hFFFFFFFF, 32'h000000E0}, '{8'h04, 32'hFFFFFFFF, 32'h00000008},
    '{8'h08, 32'hFFFFFFFF, 32'h00007777}, '{8'h0C, 32'hFFFFFFFF, 32'h00000070},
    '{8'h10, 32'hFFFFFFFF, 32'h00008000}, '{8'h00, 32'h00000000, 32'h000000E0},
    '{8'h10, 32'h00000000, 32'h00000000}, '{8'h00, 32'h00000000, 32'h00000000},
    '{8'h08, 32'h00001234, 32'h00001234}, '{8'h14, 32'hFFFFFFFF, 32'h00000000}};
  always #50 aclk = ~aclk;
  interrupt_priority_level_logic u_dut (.*);
  irq_sources u_src (.aclk, .aresetn, .want, .src_req);
  task automatic report_and_stop();
    $display("checks %0d errors %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : report_and_stop
  // each channel is released at the rising edge where its handshake is seen
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    repeat (40)
    begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready)
        s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid)
      begin
        rsp = s_axi_bresp;
        s_axi_bready <= 1'b0;
        return;
      end
    end
    err_count++;
    report_and_stop();
  endtask : wr
  task automatic rdr(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    repeat (40)
    begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready)
        s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid)
      begin
        rd = s_axi_rdata;
        rsp = s_axi_rresp;
        s_axi_rready <= 1'b0;
        return;
      end
    end
    err_count++;
    report_and_stop();
  endtask : rdr
  initial
  begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    foreach (rows[i])
    begin
      wr(rows[i].a, rows[i].d);
      `CHK(rsp, prio_pkg::RESP_OKAY)
      rdr(rows[i].a);
      `CHK(rd, rows[i].e)
    end
    s_axi_wstrb <= 4'h1;
    wr(8'h08, 32'h00000000);
    s_axi_wstrb <= 4'hF;
    rdr(8'h08);
    `CHK(rd, 32'h00001234)
    wr(8'h40, 32'h00000001);
    `CHK(rsp, prio_pkg::RESP_SLVERR)
    rdr(8'h40);
    `CHK({rsp, rd}, {prio_pkg::RESP_SLVERR, 32'h0})
    wr(8'h08, 32'h00007531);
    wr(8'h0C, 32'h00000000);
    want <= 5'h1F;
    for (int l = 0; l < 16; l++)
    begin
      lv = 4'(l);
      wr(8'h04, {28'h0, lv[3], 3'h0});
      wr(8'h00, {24'h0, lv[2:0], 5'h0});
      rdr(8'h18);
      `CHK(rd, {27'h0, lv >= 4'h7, lv})
      `CHK({user_irq_blocked, cpu_level}, {lv >= 4'h7, lv})
      `CHK(irq_accept, {1'b0, lv < 4'h1, lv < 4'h3, lv < 4'h5, lv < 4'h7})
    end
    aresetn <= 1'b0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    rdr(8'h08);
    `CHK(rd, 32'h00004444)
    rdr(8'h0C);
    `CHK(rd, 32'h00000040)
    `CHK({irq_accept, cpu_level}, {5'h1F, 4'h0})
    `CHK(user_irq_blocked, 1'b0)
    report_and_stop();
  end
endmodule : interrupt_priority_level_logic_tb
`default_nettype wire
